// ---- hw/adc_conversion_control.sv ----
`timescale 1ns/100ps
module adc_conversion_control (
	input  wire logic                               sys_clk,
	input  wire logic                               srst,
	input  wire logic [adc_ctrl_pkg::AXI_AW-1:0]    s_axi_awaddr,
	input  wire logic                               s_axi_awvalid,
	output logic                                    s_axi_awready,
	input  wire logic [adc_ctrl_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]                         s_axi_wstrb,
	input  wire logic                               s_axi_wvalid,
	output logic                                    s_axi_wready,
	output logic [1:0]                              s_axi_bresp,
	output logic                                    s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	input  wire logic [adc_ctrl_pkg::AXI_AW-1:0]    s_axi_araddr,
	input  wire logic                               s_axi_arvalid,
	output logic                                    s_axi_arready,
	output logic [adc_ctrl_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                              s_axi_rresp,
	output logic                                    s_axi_rvalid,
	input  wire logic                               s_axi_rready,
	input  wire logic [adc_ctrl_pkg::NUM_SRC-1:0]   trigger_flags,
	input  wire logic                               cpu_halted,
	input  wire logic                               quiet_sleep_mode,
	input  wire logic                               comp_high,
	output logic [adc_ctrl_pkg::RES_W-1:0]          dac_code,
	output logic                                    sample_hold,
	output logic [adc_ctrl_pkg::CHAN_W-1:0]         active_channel,
	output logic [adc_ctrl_pkg::REF_W-1:0]          active_reference,
	output logic [adc_ctrl_pkg::GAIN_W-1:0]         active_gain,
	output logic                                    active_bipolar,
	output logic                                    converter_powered,
	output logic                                    irq_req
);
	import adc_ctrl_pkg::*;

	typedef struct packed {
		logic                 awready;
		logic                 wready;
		logic                 arready;
		logic                 aw_full;
		logic [AXI_AW-1:0]    aw_addr;
		logic                 w_full;
		logic [DATA_W-1:0]    w_data;
		logic [3:0]           w_strb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [DATA_W-1:0]    rdata;
		logic [1:0]           rresp;
		logic                 enable;
		logic                 start;
		logic                 auto_trig;
		logic                 flag;
		logic                 irq_en;
		logic [PSC_W-1:0]     presc;
		logic                 bipolar;
		logic [SRC_W-1:0]     trig_src;
		logic [GAIN_W-1:0]    gain;
		logic [CHAN_W-1:0]    channel;
		logic [REF_W-1:0]     reference;
		logic [RES_W-1:0]     result;
		conv_state_t          state;
		logic [3:0]           bit_idx;
		logic [1:0]           sample_cnt;
		logic [RES_W-1:0]     trial;
		logic [CHAN_W-1:0]    act_channel;
		logic [REF_W-1:0]     act_ref;
		logic [GAIN_W-1:0]    act_gain;
		logic                 act_bipolar;
		logic                 sample_hold;
		logic                 trig_prev;
		logic                 halt_prev;
		logic                 powered;
		logic                 irq;
	} ctrl_state_t;

	ctrl_state_t s_reg;
	ctrl_state_t s_next;
	logic        adc_tick;

	adc_prescaler adc_prescaler_i (
		.sys_clk (sys_clk),
		.srst    (srst),
		.run     (s_reg.enable),
		.select  (s_reg.presc),
		.tick    (adc_tick)
	);

	function automatic logic [DATA_W-1:0] read_word(
		input ctrl_state_t s,
		input logic [AXI_AW-1:0] addr
	);
		logic [DATA_W-1:0] w;
		w = '0;
		case (addr)
			CTRL_A_OFS: begin
				w[A_ENABLE] = s.enable;
				w[A_START] = s.start;
				w[A_AUTO] = s.auto_trig;
				w[A_FLAG] = s.flag;
				w[A_IRQEN] = s.irq_en;
				w[A_PSC_LO +: PSC_W] = s.presc;
			end
			CTRL_B_OFS: begin
				w[B_BIPOLAR] = s.bipolar;
				w[B_SRC_LO +: SRC_W] = s.trig_src;
				w[B_GAIN_LO +: GAIN_W] = s.gain;
			end
			SEL_OFS: begin
				w[S_CHAN_LO +: CHAN_W] = s.channel;
				w[S_REF_LO +: REF_W] = s.reference;
			end
			RESULT_OFS: begin
				w[RES_W-1:0] = s.result;
			end
			default: begin
				w = '0;
			end
		endcase
		return w;
	endfunction

	function automatic logic mapped(input logic [AXI_AW-1:0] addr);
		return addr == CTRL_A_OFS || addr == CTRL_B_OFS ||
			addr == SEL_OFS || addr == RESULT_OFS;
	endfunction

	always_comb begin
		logic sel_level;
		logic trig_edge;
		logic halt_edge;
		logic do_write;
		logic sw_start;
		logic done;
		logic flag_clear;
		logic [RES_W-1:0] t;
		sel_level = 1'b0;
		trig_edge = 1'b0;
		halt_edge = 1'b0;
		do_write = 1'b0;
		sw_start = 1'b0;
		done = 1'b0;
		flag_clear = 1'b0;
		t = s_reg.trial;
		s_next = s_reg;

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_full = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		do_write = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
		if (do_write) begin
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = mapped(s_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (s_reg.w_strb[0]) begin
				case (s_reg.aw_addr)
					CTRL_A_OFS: begin
						s_next.enable = s_reg.w_data[A_ENABLE];
						s_next.auto_trig = s_reg.w_data[A_AUTO];
						s_next.irq_en = s_reg.w_data[A_IRQEN];
						s_next.presc = s_reg.w_data[A_PSC_LO +: PSC_W];
						sw_start = s_reg.w_data[A_START];
						flag_clear = s_reg.w_data[A_FLAG];
					end
					CTRL_B_OFS: begin
						s_next.bipolar = s_reg.w_data[B_BIPOLAR];
						s_next.trig_src = s_reg.w_data[B_SRC_LO +: SRC_W];
						s_next.gain = s_reg.w_data[B_GAIN_LO +: GAIN_W];
					end
					SEL_OFS: begin
						// Takes effect when the next conversion latches it
						s_next.channel = s_reg.w_data[S_CHAN_LO +: CHAN_W];
						s_next.reference[1:0] = s_reg.w_data[S_REF_LO +: 2];
					end
					default: begin
					end
				endcase
			end
			if (s_reg.w_strb[1] && s_reg.aw_addr == SEL_OFS) begin
				s_next.reference[2] = s_reg.w_data[S_REF_LO + 2];
			end
		end

		// Read channel
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = read_word(s_reg, s_axi_araddr);
			s_next.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end

		// Flags of other units act as triggers whatever their masks
		sel_level = trigger_flags[s_reg.trig_src];
		s_next.trig_prev = sel_level;
		trig_edge = sel_level && !s_reg.trig_prev;
		s_next.halt_prev = cpu_halted && quiet_sleep_mode;
		halt_edge = cpu_halted && quiet_sleep_mode && !s_reg.halt_prev;

		case (s_reg.state)
			CONV_IDLE: begin
				s_next.sample_hold = 1'b0;
				if (s_reg.enable && (sw_start ||
					(s_reg.auto_trig && s_reg.trig_src != SRC_SELF &&
					trig_edge) ||
					(!s_reg.auto_trig && s_reg.irq_en && halt_edge))) begin
					s_next.state = CONV_SAMPLE;
					s_next.start = 1'b1;
					s_next.sample_cnt = 2'h0;
				end
			end
			CONV_SAMPLE: begin
				// Edges during a conversion are dropped, not queued
				s_next.sample_hold = 1'b1;
				if (adc_tick) begin
					if (s_reg.sample_cnt == 2'h0) begin
						// Latched one converter clock after start
						s_next.act_channel = s_reg.channel;
						s_next.act_ref = s_reg.reference;
						s_next.act_gain = s_reg.gain;
						s_next.act_bipolar = s_reg.bipolar;
					end
					s_next.sample_cnt = s_reg.sample_cnt + 2'h1;
					if (s_reg.sample_cnt == SAMPLE_TICKS - 2'h1) begin
						s_next.state = CONV_STEP;
						s_next.sample_hold = 1'b0;
						s_next.trial = MSB_ONLY;
						s_next.bit_idx = RES_MSB;
					end
				end
			end
			CONV_STEP: begin
				if (adc_tick) begin
					// Input below trial clears the bit; a negative
					// unipolar difference ends at zero
					if (!comp_high) begin
						t[s_reg.bit_idx] = 1'b0;
					end
					// Input above reference keeps every bit
					if (s_reg.bit_idx == 4'h0) begin
						done = 1'b1;
					end else begin
						t[s_reg.bit_idx - 4'h1] = 1'b1;
						s_next.bit_idx = s_reg.bit_idx - 4'h1;
					end
					s_next.trial = t;
				end
			end
			default: begin
				s_next.state = CONV_IDLE;
			end
		endcase

		if (done) begin
			// Offset binary to two's complement; bit nine is the sign
			s_next.result = s_reg.act_bipolar ?
				{~t[RES_W-1], t[RES_W-2:0]} : t;
			s_next.state = CONV_IDLE;
			s_next.start = 1'b0;
			if (s_reg.auto_trig && s_reg.trig_src == SRC_SELF) begin
				// Free-running ignores whether the flag was cleared
				s_next.state = CONV_SAMPLE;
				s_next.start = 1'b1;
				s_next.sample_cnt = 2'h0;
			end
		end

		// Set beats clear in the same cycle
		if (done) begin
			s_next.flag = 1'b1;
		end else if (flag_clear) begin
			s_next.flag = 1'b0;
		end

		if (!s_next.enable) begin
			s_next.state = CONV_IDLE;
			s_next.start = 1'b0;
			s_next.sample_hold = 1'b0;
		end
		// Stays powered in any sleep mode; only enable gates it
		s_next.powered = s_next.enable;
		// Raised regardless of CPU wake state
		s_next.irq = s_next.flag && s_next.irq_en;

		s_next.awready = !s_next.aw_full && !s_next.bvalid;
		s_next.wready = !s_next.w_full && !s_next.bvalid;
		s_next.arready = !s_next.rvalid;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign dac_code = s_reg.trial;
	assign sample_hold = s_reg.sample_hold;
	assign active_channel = s_reg.act_channel;
	assign active_reference = s_reg.act_ref;
	assign active_gain = s_reg.act_gain;
	assign active_bipolar = s_reg.act_bipolar;
	assign converter_powered = s_reg.powered;
	assign irq_req = s_reg.irq;
endmodule

// ---- hw/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
	localparam int AXI_AW = 4;
	localparam int DATA_W = 32;
	localparam int RES_W  = 10;
	localparam int CHAN_W = 6;
	localparam int REF_W  = 3;
	localparam int PSC_W  = 3;
	localparam int SRC_W  = 3;
	localparam int GAIN_W = 2;
	localparam int NUM_SRC = 8;

	localparam logic [AXI_AW-1:0] CTRL_A_OFS = 4'h0;
	localparam logic [AXI_AW-1:0] CTRL_B_OFS = 4'h4;
	localparam logic [AXI_AW-1:0] SEL_OFS    = 4'h8;
	localparam logic [AXI_AW-1:0] RESULT_OFS = 4'hC;

	// converter_ctrl_status_a
	localparam int A_ENABLE = 0;
	localparam int A_START  = 1;
	localparam int A_AUTO   = 2;
	localparam int A_FLAG   = 3;
	localparam int A_IRQEN  = 4;
	localparam int A_PSC_LO = 5;
	// converter_ctrl_status_b
	localparam int B_BIPOLAR = 0;
	localparam int B_SRC_LO  = 1;
	localparam int B_GAIN_LO = 4;
	// channel_reference_select_reg
	localparam int S_CHAN_LO = 0;
	localparam int S_REF_LO  = 6;

	localparam logic [GAIN_W-1:0] GAIN_1X  = 2'h0;
	localparam logic [GAIN_W-1:0] GAIN_8X  = 2'h1;
	localparam logic [GAIN_W-1:0] GAIN_20X = 2'h2;
	localparam logic [GAIN_W-1:0] GAIN_32X = 2'h3;

	// Source 0 is the converter's own completion flag
	localparam logic [SRC_W-1:0] SRC_SELF = 3'h0;

	localparam logic [1:0] SAMPLE_TICKS = 2'h3;
	localparam logic [3:0] RES_MSB      = 4'h9;
	localparam logic [RES_W-1:0] MSB_ONLY = 10'h200;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_SAMPLE,
		CONV_STEP
	} conv_state_t;
endpackage

// ---- hw/adc_prescaler.sv ----
`timescale 1ns/100ps
module adc_prescaler (
	input  wire logic                      sys_clk,
	input  wire logic                      srst,
	input  wire logic                      run,
	input  wire logic [adc_ctrl_pkg::PSC_W-1:0] select,
	output logic                           tick
);
	import adc_ctrl_pkg::*;

	typedef struct packed {
		logic [7:0] count;
		logic       tick;
	} psc_state_t;

	psc_state_t s_reg;
	psc_state_t s_next;
	logic [7:0] limit;

	always_comb begin
		// Divide by 2, 4, ... 256
		limit = 8'((9'h002 << select) - 9'h001);
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (!run) begin
			s_next.count = 8'h00;
		end else if (s_reg.count >= limit) begin
			s_next.count = 8'h00;
			s_next.tick = 1'b1;
		end else begin
			s_next.count = s_reg.count + 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;
endmodule

// ---- test/adc_conversion_control_properties.sv ----
`timescale 1ns/100ps
module adc_conversion_control_properties (
	input wire logic                             sys_clk,
	input wire logic                             srst,
	input wire logic                             s_axi_awready,
	input wire logic                             s_axi_wready,
	input wire logic                             s_axi_bvalid,
	input wire logic                             s_axi_bready,
	input wire logic                             s_axi_arvalid,
	input wire logic                             s_axi_arready,
	input wire logic                             s_axi_rvalid,
	input wire logic                             s_axi_rready,
	input wire logic                             sample_hold,
	input wire logic [adc_ctrl_pkg::CHAN_W-1:0]  active_channel,
	input wire logic [adc_ctrl_pkg::REF_W-1:0]   active_reference,
	input wire logic [adc_ctrl_pkg::GAIN_W-1:0]  active_gain,
	input wire logic                             active_bipolar,
	input wire logic                             converter_powered
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("read address accepted while data pending");
	property p_aw_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_block: assert property (p_aw_block)
		else $error("write accepted while response pending");
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read data late after address taken");
	property p_read_release;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_read_release: assert property (p_read_release)
		else $error("read channel not released");
	property p_write_answer;
		$rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
	endproperty
	a_write_answer: assert property (p_write_answer)
		else $error("write response before both halves taken");
	property p_write_release;
		s_axi_bvalid && s_axi_bready
			|=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_write_release: assert property (p_write_release)
		else $error("write channel not released");
	// Selection may only move while a sample is being taken
	property p_sel_latch;
		$changed(active_channel) || $changed(active_reference)
			|-> sample_hold || $past(sample_hold);
	endproperty
	a_sel_latch: assert property (p_sel_latch)
		else $error("selection changed outside sampling");
	property p_mode_latch;
		$changed(active_gain) || $changed(active_bipolar)
			|-> sample_hold || $past(sample_hold);
	endproperty
	a_mode_latch: assert property (p_mode_latch)
		else $error("gain or polarity changed outside sampling");
	property p_power;
		sample_hold && $past(sample_hold) |-> converter_powered;
	endproperty
	a_power: assert property (p_power)
		else $error("sampling while converter unpowered");
endmodule

bind adc_conversion_control adc_conversion_control_properties
	adc_conversion_control_properties_i (.sys_clk, .srst, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .sample_hold,
	.active_channel, .active_reference, .active_gain, .active_bipolar,
	.converter_powered);

// ---- test/adc_conversion_control_tb_top.sv ----
`timescale 1ns/100ps
module adc_conversion_control_tb_top;
	import adc_ctrl_pkg::*;
	typedef struct {
		logic        is_w;
		logic [1:0]  resp;
		logic [31:0] exp;
		logic [31:0] mask;
	} note_t;
	logic               sys_clk = 0, srst = 1, comp_high = 0;
	logic [3:0]         s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [31:0]        s_axi_wdata = 0, s_axi_rdata;
	logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic               s_axi_arvalid = 0, s_axi_rready = 0;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic               s_axi_arready, s_axi_rvalid, sample_hold;
	logic [1:0]         s_axi_bresp, s_axi_rresp, active_gain;
	logic [7:0]         trigger_flags = 0;
	logic               cpu_halted = 0, quiet_sleep_mode = 0, prev_sh = 0;
	logic [9:0]         dac_code, exp;
	logic [5:0]         active_channel, ch;
	logic [2:0]         active_reference, rf, ps;
	logic               active_bipolar, converter_powered, irq_req, bip;
	logic [10:0]        vin = 0;
	int                 err_count = 0, tests_run = 0, seed = 44;
	int                 conv_cnt = 0, fall_cnt = 0, c0, f0;
	note_t              notes[$];
	note_t              cur;

	adc_conversion_control adc_conversion_control_i (.sys_clk, .srst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .trigger_flags, .cpu_halted, .quiet_sleep_mode,
		.comp_high, .dac_code, .sample_hold, .active_channel,
		.active_reference, .active_gain, .active_bipolar,
		.converter_powered, .irq_req);

	always #25 sys_clk = ~sys_clk;

	// Comparator lags a cycle; trial codes settle for a full tick anyway
	always @(posedge sys_clk) begin
		comp_high <= ({1'b0, dac_code} <= vin);
		prev_sh <= sample_hold;
		if (sample_hold && !prev_sh)
			conv_cnt <= conv_cnt + 1;
		if (!sample_hold && prev_sh)
			fall_cnt <= fall_cnt + 1;
	end

	task report_and_stop;
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task timeout;
		err_count++;
		report_and_stop();
	endtask

	task check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	always @(posedge sys_clk) begin
		if (!srst && notes.size() > 0 && ((s_axi_bvalid && s_axi_bready)
				|| (s_axi_rvalid && s_axi_rready))) begin
			cur = notes.pop_front();
			check(32'(cur.is_w ? s_axi_bresp : s_axi_rresp), 32'(cur.resp));
			if (!cur.is_w)
				check(s_axi_rdata & cur.mask, cur.exp);
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] d,
			input logic [1:0] r);
		bit ok = 0;
		notes.push_back('{1'b1, r, 32'h0, 32'h0});
		@(posedge sys_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (int t = 0; t < 200 && !ok; t++) begin
			@(posedge sys_clk);
			ok = s_axi_bvalid;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		if (!ok)
			timeout();
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e,
			input logic [31:0] m, input logic [1:0] r);
		bit ok = 0;
		notes.push_back('{1'b0, r, e, m});
		@(posedge sys_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (int t = 0; t < 200 && !ok; t++) begin
			@(posedge sys_clk);
			ok = s_axi_rvalid;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (!ok)
			timeout();
	endtask

	// Kind 0 waits for the request, 1 for starts, 2 for sampling ends
	task automatic wait_for(input int k, input int n);
		bit ok = 0;
		for (int t = 0; t < 3000 && !ok; t++) begin
			@(posedge sys_clk);
			ok = (k == 0) ? irq_req === 1'b1 : (k == 1) ? conv_cnt >= n
				: fall_cnt >= n;
		end
		if (!ok)
			timeout();
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		rd(CTRL_A_OFS, 32'h0, 32'hFF, RESP_OKAY);
		rd(CTRL_B_OFS, 32'h0, 32'h3F, RESP_OKAY);
		rd(RESULT_OFS, 32'h0, 32'h3FF, RESP_OKAY);
		rd(4'h2, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
		wr(4'h6, 32'hFF, RESP_SLVERR);
		$display("test register map done");
		for (int i = 0; i < 4; i++) begin
			bip = i[1];
			// Last pass divides by 128: about 156 kHz, full resolution
			ps = 3'(i * 2);
			ch = 6'($random(seed));
			rf = 3'($random(seed));
			vin = (i == 1) ? 11'h500 : (i == 2) ? 11'($random(seed)) & 11'h3FF : 0;
			exp = bip ? {~vin[9], vin[8:0]} : (vin[10] ? 10'h3FF : vin[9:0]);
			wr(CTRL_B_OFS, 32'(i) << B_GAIN_LO | 32'(bip), RESP_OKAY);
			wr(SEL_OFS, {23'h0, rf, ch}, RESP_OKAY);
			wr(CTRL_A_OFS, 32'(ps) << A_PSC_LO | 32'h11, RESP_OKAY);
			wr(CTRL_A_OFS, 32'(ps) << A_PSC_LO | 32'h13, RESP_OKAY);
			rd(CTRL_A_OFS, 32'h2, 32'h2, RESP_OKAY);
			wait_for(0, 0);
			rd(RESULT_OFS, 32'(exp), 32'h3FF, RESP_OKAY);
			check(32'(active_gain), 32'(i));
			check(32'({active_bipolar, rf, ch}), 32'({bip, active_reference, active_channel}));
			rd(CTRL_A_OFS, 32'(ps) << A_PSC_LO | 32'h19, 32'hFF, RESP_OKAY);
			wr(CTRL_A_OFS, 32'(ps) << A_PSC_LO | 32'h19, RESP_OKAY);
		end
		$display("test single conversions done");
		wr(CTRL_A_OFS, 32'h05, RESP_OKAY);
		for (int s = 1; s < 8; s++) begin
			wr(CTRL_B_OFS, 32'(s) << B_SRC_LO, RESP_OKAY);
			c0 = conv_cnt;
			@(posedge sys_clk);
			trigger_flags[s] <= 1'b1;
			wait_for(1, c0 + 1);
			@(posedge sys_clk);
			trigger_flags[s] <= 1'b0;
			@(posedge sys_clk);
			trigger_flags[s] <= 1'b1;
			repeat (60) @(posedge sys_clk);
			check(32'(conv_cnt), 32'(c0 + 1));
			trigger_flags[s] <= 1'b0;
		end
		$display("test trigger sources done");
		wr(CTRL_B_OFS, 32'h0, RESP_OKAY);
		// Reference moves back to zero; free-run results stay unread
		wr(SEL_OFS, 32'h0A, RESP_OKAY);
		f0 = fall_cnt;
		wr(CTRL_A_OFS, 32'h07, RESP_OKAY);
		wait_for(2, f0 + 2);
		wr(SEL_OFS, 32'h15, RESP_OKAY);
		check(32'(active_channel), 32'h0A);
		wait_for(2, f0 + 3);
		check(32'(active_channel), 32'h15);
		rd(CTRL_A_OFS, 32'h0F, 32'hFF, RESP_OKAY);
		wr(CTRL_A_OFS, 32'h08, RESP_OKAY);
		$display("test free running done");
		wr(CTRL_A_OFS, 32'h19, RESP_OKAY);
		c0 = conv_cnt;
		@(posedge sys_clk);
		quiet_sleep_mode <= 1'b1;
		cpu_halted <= 1'b1;
		wait_for(1, c0 + 1);
		@(posedge sys_clk);
		cpu_halted <= 1'b0;
		wait_for(0, 0);
		check(32'(conv_cnt), 32'(c0 + 1));
		// Deep sleep: halted outside the quiet modes, still enabled
		quiet_sleep_mode <= 1'b0;
		cpu_halted <= 1'b1;
		repeat (2) @(posedge sys_clk);
		check(32'(converter_powered), 32'h1);
		wr(CTRL_A_OFS, 32'h08, RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		check(32'(converter_powered), 32'h0);
		$display("test sleep start done");
		report_and_stop();
	end
endmodule
